// File: rtl/ssp_cfg.svh
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Register indices; byte address is four times the index
`define SSP_IDX_PRI    6'h18
`define SSP_IDX_SEC    6'h19
`define SSP_IDX_MOD    6'h1a
`define SSP_IDX_CMD    6'h1b
`define SSP_IDX_STAT   6'h1c

// Reset values
`define SSP_PRI_RST    8'hf8
`define SSP_SEC_RST    8'h18
`define SSP_MOD_RST    8'h00

// Field positions
`define SSP_EN_BIT     0
`define SSP_SYNC_BIT   1
`define SSP_GAIN_BIT   4
`define SSP_BOOST_BIT  5
`define SSP_LOAD_BIT   7
`define SSP_SEC_WMASK  8'h1f

// Derived settings
`define SSP_STEP_NORM  6'h1c
`define SSP_STEP_BOOST 6'h38
`define SSP_WIDTH_BASE 5'h08
`define SSP_WIDTH_GAIN 5'h10
`define SSP_RATE_X1    3'h1
`define SSP_RATE_X2    3'h2
`define SSP_RATE_X4    3'h4

// Bus responses
`define SSP_RESP_OKAY  2'h0
`define SSP_RESP_SLVE  2'h2

`endif

// File: rtl/ssp_pkg.sv
package ssp_pkg;

    typedef enum logic [1:0]
    {
        ssp_st_idle,
        ssp_st_wait,
        ssp_st_run
    } ssp_mod_state_t;

endpackage

// File: rtl/ssp_top.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module ssp_top
    import ssp_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Line timing pin
    input  wire logic        line_transfer_pulse,
    // Analog settings
    output logic [2:0]       pll_range,
    output logic [1:0]       primary_pll_pump,
    output logic [2:0]       primary_pll_bw,
    output logic [1:0]       secondary_pll_pump,
    output logic [2:0]       secondary_pll_bw,
    // Modulator settings and state
    output logic [2:0]       mod_rate_factor,
    output logic [5:0]       mod_step_div,
    output logic [4:0]       mod_width_units,
    output logic             mod_active,
    output logic             mod_waiting,
    output logic             mod_reload
);

    logic [7:0]     pri_reg, pri_next;
    logic [7:0]     sec_reg, sec_next;
    logic [7:0]     mod_reg, mod_next;
    logic [7:0]     awaddr_reg, awaddr_next;
    logic [7:0]     wdata_reg, wdata_next;
    logic           wstrb_reg, wstrb_next;
    logic           aw_full_reg, aw_full_next;
    logic           w_full_reg, w_full_next;
    logic           awready_reg, awready_next;
    logic           wready_reg, wready_next;
    logic           bvalid_reg, bvalid_next;
    logic [1:0]     bresp_reg, bresp_next;
    logic           arready_reg, arready_next;
    logic           rvalid_reg, rvalid_next;
    logic [31:0]    rdata_reg, rdata_next;
    logic [1:0]     rresp_reg, rresp_next;
    logic           aw_take, w_take, ar_take;
    logic           aw_have, w_have, do_write;
    logic [5:0]     wr_idx;
    logic [7:0]     wr_data;
    logic           wr_lane;
    logic           load_req;
    ssp_mod_state_t state_reg, state_next;
    logic           active_reg, active_next;
    logic           waiting_reg, waiting_next;
    logic           reload_reg, reload_next;
    logic           en_rise, reload;
    logic [2:0]     rate_reg, rate_next;
    logic [5:0]     step_reg, step_next;
    logic [4:0]     width_reg, width_next;
    logic           line_meta_reg, line_sync_reg, line_prev_reg;
    logic           line_edge;
    assign line_edge = line_sync_reg && !line_prev_reg;
    // Register slave; address and data may arrive in either order
    always_comb
    begin
        aw_take = s_axi_awvalid && awready_reg;
        w_take = s_axi_wvalid && wready_reg;
        aw_have = aw_full_reg || aw_take;
        w_have = w_full_reg || w_take;
        do_write = aw_have && w_have && !bvalid_reg;
        wr_idx = aw_take ? s_axi_awaddr[7:2] : awaddr_reg[7:2];
        wr_data = w_take ? s_axi_wdata[7:0] : wdata_reg;
        wr_lane = w_take ? s_axi_wstrb[0] : wstrb_reg;
        awaddr_next = aw_take ? s_axi_awaddr : awaddr_reg;
        wdata_next = w_take ? s_axi_wdata[7:0] : wdata_reg;
        wstrb_next = w_take ? s_axi_wstrb[0] : wstrb_reg;
        aw_full_next = aw_have && !do_write;
        w_full_next = w_have && !do_write;
        awready_next = !aw_full_next;
        wready_next = !w_full_next;
        bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
        bresp_next = bresp_reg;
        pri_next = pri_reg;
        sec_next = sec_reg;
        mod_next = mod_reg;
        load_req = 1'b0;
        if (do_write)
        begin
            bresp_next = `SSP_RESP_OKAY;
            case (wr_idx)
                `SSP_IDX_PRI:
                    if (wr_lane)
                        pri_next = wr_data;
                `SSP_IDX_SEC:
                    if (wr_lane)
                        sec_next = wr_data & `SSP_SEC_WMASK;
                `SSP_IDX_MOD:
                    if (wr_lane)
                        mod_next = wr_data;
                `SSP_IDX_CMD: load_req = wr_lane && wr_data[`SSP_LOAD_BIT];
                `SSP_IDX_STAT: bresp_next = `SSP_RESP_OKAY;
                default: bresp_next = `SSP_RESP_SLVE;
            endcase
        end
        ar_take = s_axi_arvalid && arready_reg;
        rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
        arready_next = !rvalid_next;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (ar_take)
        begin
            rresp_next = `SSP_RESP_OKAY;
            rdata_next = 32'h00000000;
            case (s_axi_araddr[7:2])
                `SSP_IDX_PRI: rdata_next = {24'h000000, pri_reg};
                `SSP_IDX_SEC: rdata_next = {24'h000000, sec_reg};
                `SSP_IDX_MOD: rdata_next = {24'h000000, mod_reg};
                `SSP_IDX_CMD: rresp_next = `SSP_RESP_OKAY; // Reads as zero
                `SSP_IDX_STAT:
                    rdata_next = {30'h00000000, waiting_reg, active_reg};
                default: rresp_next = `SSP_RESP_SLVE;
            endcase
        end
    end

    // Modulator start control
    always_comb
    begin
        en_rise = mod_next[`SSP_EN_BIT] && !mod_reg[`SSP_EN_BIT];
        reload = en_rise || load_req;
        state_next = state_reg;
        case (state_reg)
            ssp_st_idle: state_next = ssp_st_idle;
            ssp_st_wait:
                if (line_edge)
                    state_next = ssp_st_run;
            ssp_st_run: state_next = ssp_st_run;
            default: state_next = ssp_st_idle;
        endcase
        if (reload)
            state_next = mod_next[`SSP_SYNC_BIT] ? ssp_st_wait
                                                 : ssp_st_run;
        if (!mod_next[`SSP_EN_BIT])
            state_next = ssp_st_idle;
        active_next = (state_next == ssp_st_run);
        waiting_next = (state_next == ssp_st_wait);
        reload_next = reload;
    end

    // Settings decoded from the control field
    always_comb
    begin
        case (mod_reg[7:6])
            2'h0: rate_next = `SSP_RATE_X1;
            2'h1: rate_next = `SSP_RATE_X2;
            2'h2: rate_next = `SSP_RATE_X4;
            default: rate_next = `SSP_RATE_X1; // Reserved code held at 1x
        endcase
        step_next = mod_reg[`SSP_BOOST_BIT] ? `SSP_STEP_BOOST
                                            : `SSP_STEP_NORM;
        // Width in units of 0.625 percent
        width_next = (mod_reg[`SSP_GAIN_BIT] ? `SSP_WIDTH_GAIN
                                             : `SSP_WIDTH_BASE)
                     >> mod_reg[3:2];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pri_reg <= `SSP_PRI_RST;
            sec_reg <= `SSP_SEC_RST;
            mod_reg <= `SSP_MOD_RST;
            awaddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wstrb_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SSP_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `SSP_RESP_OKAY;
            state_reg <= ssp_st_idle;
            active_reg <= 1'b0;
            waiting_reg <= 1'b0;
            reload_reg <= 1'b0;
            rate_reg <= `SSP_RATE_X1;
            step_reg <= `SSP_STEP_NORM;
            width_reg <= `SSP_WIDTH_BASE;
            line_meta_reg <= 1'b0;
            line_sync_reg <= 1'b0;
            line_prev_reg <= 1'b0;
        end
        else
        begin
            pri_reg <= pri_next;
            sec_reg <= sec_next;
            mod_reg <= mod_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            state_reg <= state_next;
            active_reg <= active_next;
            waiting_reg <= waiting_next;
            reload_reg <= reload_next;
            rate_reg <= rate_next;
            step_reg <= step_next;
            width_reg <= width_next;
            // Pin is asynchronous; only the second and third stages feed logic
            line_meta_reg <= line_transfer_pulse;
            line_sync_reg <= line_meta_reg;
            line_prev_reg <= line_sync_reg;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pll_range = pri_reg[7:5];
    assign primary_pll_pump = pri_reg[4:3];
    assign primary_pll_bw = pri_reg[2:0];
    assign secondary_pll_pump = sec_reg[4:3];
    assign secondary_pll_bw = sec_reg[2:0];
    assign mod_rate_factor = rate_reg;
    assign mod_step_div = step_reg;
    assign mod_width_units = width_reg;
    assign mod_active = active_reg;
    assign mod_waiting = waiting_reg;
    assign mod_reload = reload_reg;

    sequence seq_sync_arm;
        $rose(mod_reg[`SSP_EN_BIT]) && mod_reg[`SSP_SYNC_BIT];
    endsequence
    // A disabling write in the same cycle legally wins over the line edge
    sequence seq_line_start;
        waiting_reg && line_edge && mod_next[`SSP_EN_BIT] && !load_req;
    endsequence
    chk_primary_defaults: assert property (
        @(posedge ref_clk) !resetn |=>
            primary_pll_pump == 2'h3 && primary_pll_bw == 3'h0)
        else $error("primary pump or bandwidth default wrong");
    chk_primary_write: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        do_write && wr_idx == `SSP_IDX_PRI && wr_lane |=>
            primary_pll_pump == $past(wr_data[4:3]) ##1
            primary_pll_bw == $past(wr_data[2:0], 2))
        else $error("primary field write not applied");
    chk_rate_mult: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        mod_reg[7:6] == 2'h2 ##1 mod_reg[7:6] == 2'h2 |->
            mod_rate_factor == 3'h4)
        else $error("4x rate not selected");
    chk_step_boost: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(mod_reg[`SSP_BOOST_BIT]) |=> mod_step_div == 6'h38)
        else $error("boost step not 1/56");
    chk_gain_double: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        mod_reg[`SSP_GAIN_BIT] |=>
            mod_width_units == (5'h10 >> $past(mod_reg[3:2])))
        else $error("gain did not double width");
    chk_width_plain: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !mod_reg[`SSP_GAIN_BIT] |=>
            mod_width_units == (5'h08 >> $past(mod_reg[3:2])))
        else $error("spread width code wrong");
    chk_start_now: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(mod_reg[`SSP_EN_BIT]) && !mod_reg[`SSP_SYNC_BIT] |->
            mod_active && !mod_waiting)
        else $error("unsynced start delayed");
    chk_sync_hold: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        seq_sync_arm |-> !mod_active && mod_waiting)
        else $error("synced start did not wait");
    chk_sync_start: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        seq_line_start |=> mod_active && !mod_waiting)
        else $error("line transfer did not start modulation");
    chk_enable_reload: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(mod_reg[`SSP_EN_BIT]) |-> mod_reload ##1 !mod_reload)
        else $error("enable edge did not reload");
    chk_reset_defaults: assert property (
        @(posedge ref_clk) !resetn |=>
            mod_reg == 8'h00 && sec_reg == 8'h18 && pri_reg == 8'hf8
            && !mod_active && !mod_waiting)
        else $error("reset defaults wrong");

endmodule

// File: test/tb.sv
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module tb;
    localparam logic [1:0] OK = `SSP_RESP_OKAY;
    localparam logic [1:0] ER = `SSP_RESP_SLVE;
    // Rate factor per code, reserved code held at 1x
    localparam logic [3:0][2:0] RF = {3'h1, 3'h4, 3'h2, 3'h1};
    // Spread width per code in 0.625 percent units
    localparam logic [3:0][4:0] WU = {5'h01, 5'h02, 5'h04, 5'h08};
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        line_transfer_pulse = 1'b0;
    logic [2:0]  pll_range;
    logic [1:0]  primary_pll_pump;
    logic [2:0]  primary_pll_bw;
    logic [1:0]  secondary_pll_pump;
    logic [2:0]  secondary_pll_bw;
    logic [2:0]  mod_rate_factor;
    logic [5:0]  mod_step_div;
    logic [4:0]  mod_width_units;
    logic        mod_active;
    logic        mod_waiting;
    logic        mod_reload;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          n_reload = 0;
    int          cycles = 0;
    int          r0;
    integer      seed = 32'h21b7a2c6;
    logic [7:0]  d;

    ssp_top u_dut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_transfer_pulse,
        .pll_range, .primary_pll_pump, .primary_pll_bw,
        .secondary_pll_pump, .secondary_pll_bw, .mod_rate_factor,
        .mod_step_div, .mod_width_units, .mod_active, .mod_waiting,
        .mod_reload);

    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge ref_clk);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, v};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge ref_clk);
            if (!aw_ok && s_axi_awready === 1'b1)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] r);
        @(posedge ref_clk);
        rq.push_back({r, 24'h0, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Pre-edge values are sampled, so the design's own updates cannot race
    always @(posedge ref_clk)
    begin
        cycles++;
        if (mod_reload === 1'b1)
            n_reload++;
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    initial
    begin
        tick(16);
        resetn <= 1'b1;
        check({pll_range, primary_pll_pump, primary_pll_bw}, 8'hf8);
        check({secondary_pll_pump, secondary_pll_bw}, 5'h18);
        check(mod_rate_factor, 3'h1);
        check({mod_step_div, mod_width_units}, {6'h1c, 5'h08});
        check({mod_active, mod_waiting, mod_reload}, 3'h0);
        rd(8'h60, 8'hf8, OK);
        rd(8'h64, 8'h18, OK);
        rd(8'h68, 8'h00, OK);
        rd(8'h7c, 8'h00, ER);
        wr(8'h74, 8'hff, ER);
        rd(8'h60, 8'hf8, OK);
        $display("reset and map test done");
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($random(seed));
            d = {i[1:0], d[5:4], i[3:2], 2'b00};
            // No line length in this block, so 4x needs no limit
            wr(8'h68, d, OK);
            tick(2);
            check(mod_rate_factor, RF[d[7:6]]);
            check(mod_step_div, d[5] ? 6'h38 : 6'h1c);
            check(mod_width_units, WU[d[3:2]] << d[4]);
            rd(8'h68, d, OK);
        end
        $display("decode test done");
        r0 = n_reload;
        wr(8'h68, 8'h01, OK);
        tick(2);
        check({mod_active, mod_waiting}, 2'b10);
        check(n_reload - r0, 1);
        rd(8'h70, 8'h01, OK);
        wr(8'h6c, 8'h80, OK);
        tick(2);
        check(n_reload - r0, 2);
        wr(8'h68, 8'h00, OK);
        tick(2);
        check({mod_active, mod_waiting}, 2'b00);
        $display("unsynced start test done");
        wr(8'h68, 8'h03, OK);
        tick(6);
        check({mod_active, mod_waiting}, 2'b01);
        rd(8'h70, 8'h02, OK);
        line_transfer_pulse <= 1'b1;
        tick(2);
        line_transfer_pulse <= 1'b0;
        tick(6);
        check({mod_active, mod_waiting}, 2'b10);
        $display("synced start test done");
        // Reserved upper bits must read back as zero
        wr(8'h64, 8'hff, OK);
        rd(8'h64, 8'h1f, OK);
        wr(8'h64, 8'h07, OK);
        tick(2);
        check({secondary_pll_pump, secondary_pll_bw}, 5'h07);
        d = 8'($random(seed));
        d[7:5] = 3'h7;
        wr(8'h60, d, OK);
        tick(2);
        check({pll_range, primary_pll_pump, primary_pll_bw}, d);
        // Lane zero off: write answered but ignored
        s_axi_wstrb <= 4'he;
        wr(8'h60, 8'h00, OK);
        s_axi_wstrb <= 4'hf;
        rd(8'h60, d, OK);
        $display("pll field test done");
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(1);
        check({mod_active, mod_waiting, secondary_pll_pump}, 4'h3);
        rd(8'h68, 8'h00, OK);
        rd(8'h64, 8'h18, OK);
        $display("second reset test done");
        conclude();
    end
endmodule
